// ===== asc_pkg.sv
// constants, field layout and state types of the strap-driven negotiation block
// ****************************************************************************
// ****************************************************************************
package asc_pkg;
  // ****************************************************************************
  // timing
  // ****************************************************************************
  localparam int ASC_CLK_NS = 10;
  localparam int ASC_PULSE_NS = 100;
  localparam int ASC_PULSE_CYC = (ASC_PULSE_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  localparam int ASC_SLOT_NS = 62500;
  localparam int ASC_SLOT_CYC = ASC_SLOT_NS / ASC_CLK_NS;
  localparam int ASC_BURST_NS = 16000000;
  localparam int ASC_BURST_CYC = ASC_BURST_NS / ASC_CLK_NS;
  localparam int ASC_DATA_WIN_NS = 93750;
  localparam int ASC_DATA_WIN_CYC = ASC_DATA_WIN_NS / ASC_CLK_NS;
  localparam int ASC_BURST_END_NS = 200000;
  localparam int ASC_BURST_END_CYC = ASC_BURST_END_NS / ASC_CLK_NS;
  localparam logic [1:0] ASC_STRAP_SETTLE = 2'h3;
  localparam logic [5:0] ASC_LAST_SLOT = 6'h20;
  localparam logic [4:0] ASC_BURST_CLOCKS = 5'h11;
  // ****************************************************************************
  // register map
  // ****************************************************************************
  localparam logic [4:0] ASC_REG_CTRL = 5'h00;
  localparam logic [4:0] ASC_REG_ADV = 5'h04;
  localparam logic [4:0] ASC_REG_PART = 5'h05;
  localparam logic [4:0] ASC_REG_STAT = 5'h10;
  localparam logic [4:0] ASC_REG_XCTL = 5'h19;
  localparam int ASC_CTRL_RESET = 15;
  localparam int ASC_CTRL_SPEED = 13;
  localparam int ASC_CTRL_NEG_EN = 12;
  localparam int ASC_CTRL_RESTART = 9;
  localparam int ASC_CTRL_DUPLEX = 8;
  localparam int ASC_ADV_ACK = 14;
  localparam int ASC_ADV_ABIL_LSB = 5;
  localparam logic [4:0] ASC_SELECTOR = 5'h01;
  localparam int ASC_XCTL_AUTO_SWAP = 15;
  localparam int ASC_XCTL_FORCE_SWAP = 14;
  localparam logic [1:0] ASC_XCTL_RESET = 2'h2;
  // ability nibble order {100 full, 100 half, 10 full, 10 half}
  localparam logic [3:0] ASC_ADV_10_BOTH = 4'h3;
  localparam logic [3:0] ASC_ADV_100_BOTH = 4'hc;
  localparam logic [3:0] ASC_ADV_HALF_BOTH = 4'h5;
  localparam logic [3:0] ASC_ADV_ALL = 4'hf;
  localparam logic [7:0] ASC_LFSR_SEED = 8'ha5;

  typedef enum logic [1:0] {ASC_FORCED, ASC_SEEK, ASC_ACK, ASC_DONE} asc_neg_t;
endpackage

// ===== asc_top.sv
// strap sampling, register control and pulse-burst negotiation of a 10/100 line
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module asc_top #(
  parameter int SLOT_CYC = asc_pkg::ASC_SLOT_CYC,
  parameter int BURST_CYC = asc_pkg::ASC_BURST_CYC,
  parameter int DATA_WIN_CYC = asc_pkg::ASC_DATA_WIN_CYC,
  parameter int BURST_END_CYC = asc_pkg::ASC_BURST_END_CYC
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // register port
  input wire logic [4:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // shared strap / led pins: negotiate enable, mode high, mode low
  input wire logic NEGOTIATE_STRAP_ENABLE_I,
  output logic NEGOTIATE_STRAP_ENABLE_O,
  output logic NEGOTIATE_STRAP_ENABLE_OE,
  input wire logic MODE_STRAP_HIGH_I,
  output logic MODE_STRAP_HIGH_O,
  output logic MODE_STRAP_HIGH_OE,
  input wire logic MODE_STRAP_LOW_I,
  output logic MODE_STRAP_LOW_O,
  output logic MODE_STRAP_LOW_OE,
  // line pairs, link pulse level
  input wire logic LINE_TRANSMIT_PAIR_I,
  output logic LINE_TRANSMIT_PAIR_O,
  input wire logic LINE_RECEIVE_PAIR_I,
  output logic LINE_RECEIVE_PAIR_O,
  // resolved operating mode
  output logic SPEED_100,
  output logic FULL_DUPLEX,
  output logic LINK_UP,
  output logic PAIRS_SWAPPED
);
  import asc_pkg::*;

  localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYC - 1);
  localparam logic [23:0] BURST_LAST = 24'(BURST_CYC - 1);
  localparam logic [15:0] DATA_WIN = 16'(DATA_WIN_CYC);
  localparam logic [15:0] BURST_END = 16'(BURST_END_CYC);
  localparam logic [3:0] PULSE_LEN = 4'(ASC_PULSE_CYC);

  // ****************************************************************************
  // input synchronisers
  // ****************************************************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [1:0] line_prev_q;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      line_prev_q <= 2'h0;
    end else begin
      sync1_q <= {LINE_RECEIVE_PAIR_I, LINE_TRANSMIT_PAIR_I, NEGOTIATE_STRAP_ENABLE_I,
                  MODE_STRAP_HIGH_I, MODE_STRAP_LOW_I};
      sync2_q <= sync1_q;
      line_prev_q <= sync2_q[4:3];
    end
  end

  // ****************************************************************************
  // strap capture window
  // ****************************************************************************
  logic [1:0] cap_cnt_q;
  logic captured_q;
  wire cap_now = !captured_q && cap_cnt_q == ASC_STRAP_SETTLE;
  wire strap_neg = sync2_q[2];
  wire [1:0] strap_mode = sync2_q[1:0];
  // pins stay undriven until the straps are latched; later pin levels never reach config
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cap_cnt_q <= 2'h0;
      captured_q <= 1'b0;
    end else if (!captured_q) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      captured_q <= cap_now;
    end
  end

  logic [3:0] strap_adv;
  always_comb begin
    case (strap_mode)
      2'h0: strap_adv = ASC_ADV_10_BOTH;
      2'h1: strap_adv = ASC_ADV_100_BOTH;
      2'h2: strap_adv = ASC_ADV_HALF_BOTH;
      default: strap_adv = ASC_ADV_ALL;
    endcase
  end
  // forced mode advertises just the one forced ability
  wire [3:0] forced_adv = 4'h1 << strap_mode;

  // ****************************************************************************
  // registers
  // ****************************************************************************
  logic neg_en_q;
  logic speed_q;
  logic duplex_q;
  logic [15:0] adv_q;
  logic [15:0] part_q;
  logic [1:0] xctl_q;
  wire wr_ctrl = REG_WR && REG_ADDR == ASC_REG_CTRL;
  wire wr_adv = REG_WR && REG_ADDR == ASC_REG_ADV;
  wire wr_xctl = REG_WR && REG_ADDR == ASC_REG_XCTL;
  wire neg_en_d = wr_ctrl ? REG_WDATA[ASC_CTRL_NEG_EN] : neg_en_q;
  // enable going low then high, restart or soft reset all start a fresh exchange
  wire restart = captured_q && ((wr_ctrl && (REG_WDATA[ASC_CTRL_RESTART]
                 || REG_WDATA[ASC_CTRL_RESET])) || (neg_en_d && !neg_en_q));

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      neg_en_q <= 1'b0;
      speed_q <= 1'b0;
      duplex_q <= 1'b0;
      adv_q <= {11'h000, ASC_SELECTOR};
      xctl_q <= ASC_XCTL_RESET;
    end else if (cap_now) begin
      neg_en_q <= strap_neg;
      speed_q <= strap_mode[1];
      duplex_q <= strap_mode[0];
      adv_q[8:5] <= strap_neg ? strap_adv : forced_adv;
    end else begin
      if (wr_ctrl) begin
        neg_en_q <= REG_WDATA[ASC_CTRL_NEG_EN];
        speed_q <= REG_WDATA[ASC_CTRL_SPEED];
        duplex_q <= REG_WDATA[ASC_CTRL_DUPLEX];
      end
      if (wr_adv) begin
        adv_q <= {REG_WDATA[15], 1'b0, REG_WDATA[13:0]};
      end
      if (wr_xctl) begin
        xctl_q <= REG_WDATA[15:14];
      end
    end
  end

  // ****************************************************************************
  // burst receiver on the pair currently used for input
  // ****************************************************************************
  logic swap_q;
  logic rx_act_q;
  logic rx_dseen_q;
  logic [4:0] rx_clks_q;
  logic [15:0] rx_gap_q;
  logic [15:0] rx_sh_q;
  wire rx_in = swap_q ? sync2_q[3] : sync2_q[4];
  wire rx_prev = swap_q ? line_prev_q[0] : line_prev_q[1];
  wire rx_rise = rx_in && !rx_prev;
  wire rx_is_data = rx_act_q && rx_gap_q < DATA_WIN && !rx_dseen_q;
  wire rx_end = rx_act_q && rx_gap_q == BURST_END;
  wire rx_word_ok = rx_end && rx_clks_q == ASC_BURST_CLOCKS
                    && rx_sh_q[4:0] == ASC_SELECTOR;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rx_act_q <= 1'b0;
      rx_dseen_q <= 1'b0;
      rx_clks_q <= 5'h00;
      rx_gap_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
    end else if (rx_rise && rx_is_data) begin
      rx_dseen_q <= 1'b1;
    end else if (rx_rise) begin
      if (rx_act_q) begin
        rx_sh_q <= {rx_dseen_q, rx_sh_q[15:1]};
        rx_clks_q <= rx_clks_q + 5'h01;
      end else begin
        rx_clks_q <= 5'h01;
      end
      rx_act_q <= 1'b1;
      rx_gap_q <= 16'h0000;
      rx_dseen_q <= 1'b0;
    end else if (rx_end) begin
      rx_act_q <= 1'b0;
    end else if (rx_act_q) begin
      rx_gap_q <= rx_gap_q + 16'h0001;
    end
  end

  // ****************************************************************************
  // negotiation state
  // ****************************************************************************
  asc_neg_t st_q;
  asc_neg_t st_d;
  wire neg_on = captured_q && neg_en_q;
  always_comb begin
    st_d = st_q;
    case (st_q)
      ASC_FORCED: if (neg_on) st_d = ASC_SEEK;
      ASC_SEEK: if (rx_word_ok) st_d = ASC_ACK;
      ASC_ACK: if (rx_word_ok && rx_sh_q[ASC_ADV_ACK]) st_d = ASC_DONE;
      ASC_DONE: st_d = ASC_DONE;
      default: st_d = ASC_FORCED;
    endcase
    if (!neg_on) begin
      st_d = ASC_FORCED;
    end else if (restart) begin
      st_d = ASC_SEEK;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_q <= ASC_FORCED;
      part_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      if (restart || !neg_on) begin
        part_q <= 16'h0000;
      end else if (rx_word_ok && st_q != ASC_DONE) begin
        part_q <= rx_sh_q;
      end
    end
  end

  // ****************************************************************************
  // resolution
  // ****************************************************************************
  wire [3:0] common = adv_q[8:5] & part_q[8:5];
  wire neg_done = st_q == ASC_DONE;
  // speed/duplex bits only matter while negotiation is off
  wire res_100 = neg_on ? (common[3] || common[2]) : speed_q;
  wire res_full = neg_on ? (common[3] || (!common[2] && common[1])) : duplex_q;
  wire res_link = neg_on ? (neg_done && common != 4'h0) : captured_q;

  // ****************************************************************************
  // burst transmitter and crossover
  // ****************************************************************************
  logic tx_busy_q;
  logic [5:0] tx_slot_q;
  logic [15:0] tx_stc_q;
  logic [23:0] tx_bt_q;
  logic [3:0] tx_pw_q;
  logic heard_q;
  logic [7:0] lfsr_q;
  wire seeking = st_q == ASC_SEEK || st_q == ASC_ACK;
  wire [15:0] tx_word = {adv_q[15], st_q == ASC_ACK, adv_q[13:0]};
  wire tx_start = seeking && !tx_busy_q && tx_bt_q == 24'h000000;
  wire tx_bit = tx_word[tx_slot_q[4:1]];
  wire tx_fire = tx_busy_q && tx_stc_q == 16'h0000 && (!tx_slot_q[0] || tx_bit);
  wire slot_end = tx_stc_q == SLOT_LAST;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tx_busy_q <= 1'b0;
      tx_slot_q <= 6'h00;
      tx_stc_q <= 16'h0000;
      tx_bt_q <= 24'h000000;
      tx_pw_q <= 4'h0;
    end else begin
      if (!seeking || restart) begin
        tx_bt_q <= 24'h000000;
      end else if (tx_start) begin
        tx_bt_q <= BURST_LAST;
      end else if (tx_bt_q != 24'h000000) begin
        tx_bt_q <= tx_bt_q - 24'h000001;
      end
      if (tx_start) begin
        tx_busy_q <= 1'b1;
        tx_slot_q <= 6'h00;
        tx_stc_q <= 16'h0000;
      end else if (tx_busy_q) begin
        tx_stc_q <= slot_end ? 16'h0000 : tx_stc_q + 16'h0001;
        if (slot_end) begin
          tx_slot_q <= tx_slot_q + 6'h01;
          tx_busy_q <= tx_slot_q != ASC_LAST_SLOT;
        end
      end
      if (tx_fire) begin
        tx_pw_q <= PULSE_LEN;
      end else if (tx_pw_q != 4'h0) begin
        tx_pw_q <= tx_pw_q - 4'h1;
      end
    end
  end

  // random crossover choice each burst while nobody answers
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      heard_q <= 1'b0;
      lfsr_q <= ASC_LFSR_SEED;
      swap_q <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      if (tx_start) begin
        heard_q <= 1'b0;
      end else if (rx_act_q) begin
        heard_q <= 1'b1;
      end
      if (xctl_q[0]) begin
        swap_q <= 1'b1;
      end else if (!xctl_q[1] || !neg_on) begin
        swap_q <= 1'b0; // automatic crossover needs negotiation
      end else if (tx_start && !heard_q && st_q == ASC_SEEK) begin
        swap_q <= lfsr_q[0];
      end
    end
  end

  // ****************************************************************************
  // register read and outputs
  // ****************************************************************************
  wire [15:0] ctrl_rd = {2'h0, speed_q, neg_en_q, 3'h0, duplex_q, 8'h00};
  wire [15:0] stat_rd = {12'h000, neg_done, res_full, res_100, res_link};
  wire [15:0] xctl_rd = {xctl_q, 14'h0000};
  wire [15:0] rd_mux = REG_ADDR == ASC_REG_CTRL ? ctrl_rd :
                       REG_ADDR == ASC_REG_ADV ? adv_q :
                       REG_ADDR == ASC_REG_PART ? part_q :
                       REG_ADDR == ASC_REG_STAT ? stat_rd :
                       REG_ADDR == ASC_REG_XCTL ? xctl_rd : 16'h0000;
  wire tx_pulse = tx_pw_q != 4'h0;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
      NEGOTIATE_STRAP_ENABLE_O <= 1'b0;
      NEGOTIATE_STRAP_ENABLE_OE <= 1'b0;
      MODE_STRAP_HIGH_O <= 1'b0;
      MODE_STRAP_HIGH_OE <= 1'b0;
      MODE_STRAP_LOW_O <= 1'b0;
      MODE_STRAP_LOW_OE <= 1'b0;
      LINE_TRANSMIT_PAIR_O <= 1'b0;
      LINE_RECEIVE_PAIR_O <= 1'b0;
      SPEED_100 <= 1'b0;
      FULL_DUPLEX <= 1'b0;
      LINK_UP <= 1'b0;
      PAIRS_SWAPPED <= 1'b0;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
      NEGOTIATE_STRAP_ENABLE_OE <= captured_q;
      MODE_STRAP_HIGH_OE <= captured_q;
      MODE_STRAP_LOW_OE <= captured_q;
      NEGOTIATE_STRAP_ENABLE_O <= captured_q && res_link && (rx_act_q || tx_pulse);
      MODE_STRAP_HIGH_O <= captured_q && res_100;
      MODE_STRAP_LOW_O <= captured_q && res_link;
      LINE_TRANSMIT_PAIR_O <= tx_pulse && !swap_q;
      LINE_RECEIVE_PAIR_O <= tx_pulse && swap_q;
      SPEED_100 <= captured_q && res_100;
      FULL_DUPLEX <= captured_q && res_full;
      LINK_UP <= res_link;
      PAIRS_SWAPPED <= swap_q;
    end
  end
endmodule // asc_top
`default_nettype wire

// ===== asc_properties.sv
// port assertions and covers for the strap negotiation block
`timescale 1ns/1ns
`default_nettype none
module asc_properties
  import asc_pkg::*;
(
  // clock, reset, register port
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [4:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  // pins and status
  input wire logic NEGOTIATE_STRAP_ENABLE_OE,
  input wire logic LINE_TRANSMIT_PAIR_O,
  input wire logic LINE_RECEIVE_PAIR_O,
  input wire logic LINK_UP,
  input wire logic PAIRS_SWAPPED
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire logic oe = NEGOTIATE_STRAP_ENABLE_OE;
  wire logic tx = LINE_TRANSMIT_PAIR_O;
  wire logic mapped = REG_ADDR inside {ASC_REG_CTRL, ASC_REG_ADV, ASC_REG_PART,
    ASC_REG_STAT, ASC_REG_XCTL};
  // ****
  // checks
  // ****
  a_oe_release: assert property ($fell(RST) |-> (!oe)[*4] ##[1:2] oe)
    else $error("strap pins released at wrong time");
  a_oe_hold: assert property (oe |=> oe)
    else $error("strap pins taken back");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (REG_RD && !mapped |=> REG_RDATA == 16'h0)
    else $error("unmapped read not zero");
  a_adv_ack_ro: assert property (REG_RD && REG_ADDR == ASC_REG_ADV
    |=> !REG_RDATA[ASC_ADV_ACK])
    else $error("acknowledge bit readable");
  a_restart_self: assert property (REG_RD && REG_ADDR == ASC_REG_CTRL
    |=> !REG_RDATA[ASC_CTRL_RESTART])
    else $error("restart bit reads one");
  a_status_upper: assert property (REG_RD && REG_ADDR == ASC_REG_STAT
    |=> REG_RDATA[15:4] == 12'h0)
    else $error("status upper bits set");
  a_pulse_width: assert property ($rose(tx) |-> tx[*8] ##1 tx ##1 tx ##1 !tx)
    else $error("link pulse width wrong");
  a_pair_tx: assert property ($rose(tx) |-> !PAIRS_SWAPPED)
    else $error("pulse on transmit pair while crossed");
  a_pair_rx: assert property ($rose(LINE_RECEIVE_PAIR_O) |-> PAIRS_SWAPPED)
    else $error("pulse on receive pair while straight");
  c_link: cover property ($rose(LINK_UP));
  c_swap: cover property ($rose(PAIRS_SWAPPED));
  c_unmapped: cover property (REG_RD && !mapped);
endmodule // asc_properties
bind asc_top asc_properties i_asc_properties (.*);
`default_nettype wire

// ===== asc_link_partner.sv
// link partner model sending and decoding pulse bursts
`timescale 1ns/1ns
`default_nettype none
module asc_link_partner #(
  parameter int SLOT = 20,
  parameter int DW = 30
) (
  // clock, own abilities, crossover state
  input wire logic clk,
  input wire logic [3:0] abil,
  input wire logic swap,
  // device pair outputs and inputs
  input wire logic xmt_o,
  input wire logic rcv_o,
  output logic xmt_i,
  output logic rcv_i,
  // last word decoded from the device
  output logic [15:0] word_q
);
  logic tx = 1'b0;
  logic prev = 1'b0;
  logic was_d = 1'b0;
  logic [15:0] w;
  logic [15:0] sh = 16'h0;
  int gap = 0;
  int n = 0;
  // follows the device crossover, as a partner with its own crossover would
  wire logic rx = swap ? rcv_o : xmt_o;
  assign xmt_i = swap & tx;
  assign rcv_i = ~swap & tx;
  initial word_q = 16'h0;
  // word latched per burst so an ability change never splits a burst
  initial forever begin
    repeat (700) @(posedge clk);
    w = {2'h1, 5'h0, abil, 5'h01};
    for (int s = 0; s < 33; s++) begin
      tx <= s % 2 == 0 || w[s / 2];
      repeat (10) @(posedge clk);
      tx <= 1'b0;
      repeat (SLOT - 10) @(posedge clk);
    end
  end
  always @(posedge clk) begin
    prev <= rx;
    gap <= gap + 1;
    if (rx && !prev) begin
      gap <= 0;
      if (gap < DW && !was_d && n > 0) begin
        sh[n - 1] <= 1'b1;
        was_d <= 1'b1;
      end else begin
        n <= n + 1;
        was_d <= 1'b0;
      end
    end else if (gap > 3 * SLOT && n > 0) begin
      if (n == 17) word_q <= sh;
      n <= 0;
      sh <= 16'h0;
    end
  end
endmodule // asc_link_partner
`default_nettype wire

// ===== asc_top_tb.sv
// self-checking bench for the strap negotiation block
`timescale 1ns/1ns
`default_nettype none
module asc_top_tb;
  import asc_pkg::*;
  localparam logic [3:0] NV [4] = '{ASC_ADV_10_BOTH, ASC_ADV_100_BOTH, ASC_ADV_HALF_BOTH,
    ASC_ADV_ALL};
  localparam logic [3:0] NP [3] = '{4'h5, 4'h3, 4'h1};
  logic CORE_CLK, RST, REG_WR, REG_RD, rd_p;
  logic [4:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, pword;
  logic ne_o, ne_oe, mh_o, mh_oe, ml_o, ml_oe, tx_i, tx_o, rx_i, rx_o;
  logic SPEED_100, FULL_DUPLEX, LINK_UP, PAIRS_SWAPPED;
  logic [2:0] st;
  logic [3:0] abil;
  logic [31:0] q[$];
  int n_errors = 0;
  int checked = 0;
  // strap pull level shows only while the device leaves the pin alone
  wire logic ne_w = ne_oe ? ne_o : st[2];
  wire logic mh_w = mh_oe ? mh_o : st[1];
  wire logic ml_w = ml_oe ? ml_o : st[0];
  asc_top #(.SLOT_CYC(20), .BURST_CYC(2000), .DATA_WIN_CYC(30), .BURST_END_CYC(60)) i_asc_top (
    .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .NEGOTIATE_STRAP_ENABLE_I(ne_w), .NEGOTIATE_STRAP_ENABLE_O(ne_o),
    .NEGOTIATE_STRAP_ENABLE_OE(ne_oe), .MODE_STRAP_HIGH_I(mh_w), .MODE_STRAP_HIGH_O(mh_o),
    .MODE_STRAP_HIGH_OE(mh_oe), .MODE_STRAP_LOW_I(ml_w), .MODE_STRAP_LOW_O(ml_o),
    .MODE_STRAP_LOW_OE(ml_oe), .LINE_TRANSMIT_PAIR_I(tx_i), .LINE_TRANSMIT_PAIR_O(tx_o),
    .LINE_RECEIVE_PAIR_I(rx_i), .LINE_RECEIVE_PAIR_O(rx_o), .SPEED_100(SPEED_100),
    .FULL_DUPLEX(FULL_DUPLEX), .LINK_UP(LINK_UP), .PAIRS_SWAPPED(PAIRS_SWAPPED));
  asc_link_partner i_asc_link_partner (.clk(CORE_CLK), .abil(abil),
    .swap(PAIRS_SWAPPED), .xmt_o(tx_o), .rcv_o(rx_o), .xmt_i(tx_i), .rcv_i(rx_i),
    .word_q(pword));
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  // ****
  // helpers
  // ****
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    cyc(1);
    REG_WR <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    q.push_back({e, m});
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    cyc(1);
    REG_RD <= 1'b0;
    cyc(1);
  endtask
  task automatic wt(input logic v);
    for (int k = 0; k < 12000 && LINK_UP !== v; k++) cyc(1);
    chk("link", 16'(LINK_UP), 16'(v));
  endtask
  task automatic boot(input logic [2:0] s);
    st <= s;
    RST <= 1'b1;
    cyc(12);
    RST <= 1'b0;
    cyc(30);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge CORE_CLK) begin : mon
    logic [31:0] e;
    rd_p <= REG_RD;
    if (rd_p === 1'b1) begin
      e = q.pop_front();
      chk("rdata", REG_RDATA & e[15:0], e[31:16]);
    end
  end
  initial begin
    #700000;
    n_errors++;
    print_verdict();
  end
  // ****
  // tests
  // ****
  initial begin
    logic [3:0] nib, p;
    logic [1:0] r;
    logic [15:0] d;
    RST = 1'b1;
    REG_ADDR = 5'h0;
    REG_WDATA = 16'h0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    st = 3'h0;
    abil = 4'hf;
    void'($urandom(32'h507f4eb2));
    for (int s = 0; s < 8; s++) begin
      boot(3'(s));
      nib = s[2] ? NV[s[1:0]] : 4'h1 << s[1:0];
      rd(ASC_REG_ADV, {7'h0, nib, ASC_SELECTOR}, 16'hffff);
      rd(ASC_REG_CTRL, {2'h0, s[1], s[2], 3'h0, s[0], 8'h0}, 16'h3100);
      if (!s[2]) begin
        chk("speed", 16'(SPEED_100), 16'(s[1]));
        chk("duplex", 16'(FULL_DUPLEX), 16'(s[0]));
      end
      chk("oe", {13'h0, ne_oe, mh_oe, ml_oe}, 16'h0007);
      $display("test straps %0d done", s);
    end
    wt(1'b1);
    d = 16'($urandom);
    wr(ASC_REG_ADV, d);
    rd(ASC_REG_ADV, d & 16'hbfff, 16'hffff);
    wr(5'h03, d);
    rd(5'h03, 16'h0, 16'hffff);
    rd(ASC_REG_STAT, 16'h0, 16'hfff0);
    wr(ASC_REG_ADV, {7'h0, ASC_ADV_ALL, ASC_SELECTOR});
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      p = i == 3 ? 4'($urandom_range(15, 1)) : NP[i];
      r = p[3] ? 2'h3 : p[2] ? 2'h2 : p[1] ? 2'h1 : 2'h0;
      abil <= p;
      cyc(1500);
      wr(ASC_REG_CTRL, 16'h1200);
      wt(1'b0);
      wt(1'b1);
      chk("speed", 16'(SPEED_100), 16'(r[1]));
      chk("duplex", 16'(FULL_DUPLEX), 16'(r[0]));
      rd(ASC_REG_PART, {7'h0, p, ASC_SELECTOR}, 16'h01ff);
      chk("advert", pword & 16'h01ff, {7'h0, ASC_ADV_ALL, ASC_SELECTOR});
      wr(ASC_REG_CTRL, {2'h0, ~r[1], 1'b1, 3'h0, ~r[0], 8'h0});
      cyc(4);
      chk("kept", 16'(SPEED_100), 16'(r[1]));
      $display("test partner %h done", p);
    end
    for (int m = 0; m < 4; m++) begin
      wr(ASC_REG_CTRL, {2'h0, m[1], 4'h0, m[0], 8'h0});
      cyc(4);
      chk("fspeed", 16'(SPEED_100), 16'(m[1]));
      chk("fduplex", 16'(FULL_DUPLEX), 16'(m[0]));
      chk("led speed", 16'(mh_o), 16'(m[1]));
      chk("led link", 16'(ml_o), 16'h1);
    end
    $display("test forced done");
    chk("noswap", 16'(PAIRS_SWAPPED), 16'h0);
    wr(ASC_REG_XCTL, 16'h4000);
    cyc(4);
    chk("swap", 16'(PAIRS_SWAPPED), 16'h1);
    wr(ASC_REG_CTRL, 16'h1000);
    wt(1'b0);
    wt(1'b1);
    $display("test crossover done");
    print_verdict();
  end
endmodule // asc_top_tb
`default_nettype wire
